// ---- rtl/oag_pkg.sv ----
// Operation
// - seven addressing modes; each opcode class accepts only its subset
// - register mode yields the named register or even-aligned register pair
// - window pointer picks an 8-byte slice, field picks one register
// - pointer register contents form the operand address, 8 or 16 bits
// - pointer-register mode may not reach set 1 control area
// - indexed mode may not reach set 1 control area either
// - short indexed offset is sign-extended, external memory only
// - register-file index: instruction base plus working-register offset
// - memory index: register-pair base plus 8 or 16 bit offset
// - only register load indexes register file; memory loads index memory
// - direct mode supplies 16-bit address for jumps, calls and memory loads
// - vector-table call addresses a pair in lowest 256 program bytes
// - relative mode adds signed displacement to next-instruction pc
// - relative mode serves bit tests, decrement, compare, short jump
// - literal mode takes operand byte or word from instruction field
// - address bit 3 picks pointer; its top five bits join low three
// - 8-bit address with upper nibble 1100 is a working register
package oag_pkg;

  typedef enum logic [2:0] {
    OAG_MODE_REG     = 3'b000,
    OAG_MODE_PTR_REG = 3'b001,
    OAG_MODE_INDEXED = 3'b010,
    OAG_MODE_DIRECT  = 3'b011,
    OAG_MODE_VECTOR  = 3'b100,
    OAG_MODE_REL     = 3'b101,
    OAG_MODE_LITERAL = 3'b110
  } oag_mode_type;

  typedef enum logic [3:0] {
    OAG_OP_GENERIC   = 4'h0,
    OAG_OP_REG_LOAD  = 4'h1,
    OAG_OP_PROG_LOAD = 4'h2,
    OAG_OP_EXT_LOAD  = 4'h3,
    OAG_OP_JUMP      = 4'h4,
    OAG_OP_CALL      = 4'h5,
    OAG_OP_BTB_FALSE = 4'h6,
    OAG_OP_BTB_TRUE  = 4'h7,
    OAG_OP_DEC_BR    = 4'h8,
    OAG_OP_CMP_EQ    = 4'h9,
    OAG_OP_CMP_NE    = 4'ha,
    OAG_OP_SHORT_JMP = 4'hb
  } oag_op_type;

  typedef enum logic [1:0] {
    OAG_SPACE_REG  = 2'b00,
    OAG_SPACE_PROG = 2'b01,
    OAG_SPACE_EXT  = 2'b10,
    OAG_SPACE_PC   = 2'b11
  } oag_space_type;

  localparam logic [3:0]  WORK_NIBBLE    = 4'hc;
  localparam logic [1:0]  CTRL_AREA_TOP  = 2'b11;
  localparam int          WORK_SEL_BIT   = 3;
  localparam logic [7:0]  VECTOR_HI_BYTE = 8'h00;
  localparam logic [7:0]  PAIR_EVEN_MASK = 8'hfe;
  localparam logic [15:0] NULL_ADDR      = 16'h0000;
  localparam logic [7:0]  PTR_RST_0      = 8'hc0;
  localparam logic [7:0]  PTR_RST_1      = 8'hc8;

endpackage

// ---- rtl/oag_wreg_if.sv ----
`timescale 1ns/1ns
// carries one working-register resolution between core and resolver
interface oag_wreg_if;
  logic [7:0] raw_addr;
  logic       is_short;
  logic [7:0] first_ptr;
  logic [7:0] second_ptr;
  logic [7:0] reg_addr;
  logic       is_working;

  modport core (
    output raw_addr,
    output is_short,
    output first_ptr,
    output second_ptr,
    input  reg_addr,
    input  is_working
  );
  modport resolver (
    input  raw_addr,
    input  is_short,
    input  first_ptr,
    input  second_ptr,
    output reg_addr,
    output is_working
  );
endinterface

// ---- rtl/oag_wreg_resolve.sv ----
`timescale 1ns/1ns
module oag_wreg_resolve (
  oag_wreg_if.resolver wr
);
  logic [7:0] sel_ptr;

  always_comb begin
    // short fields and 1100xxxx both resolve through a window pointer
    wr.is_working = wr.is_short ||
                    (wr.raw_addr[7:4] == oag_pkg::WORK_NIBBLE);
    sel_ptr = wr.raw_addr[oag_pkg::WORK_SEL_BIT] ? wr.second_ptr
                                                 : wr.first_ptr;
    if (wr.is_working) begin
      wr.reg_addr = {sel_ptr[7:3], wr.raw_addr[2:0]};
    end else begin
      wr.reg_addr = wr.raw_addr;
    end
  end
endmodule

// ---- rtl/oag_top.sv ----
`timescale 1ns/1ns
module oag_top (
  // clock and reset
  input  wire logic                   SYS_CLK,
  input  wire logic                   NRST,
  // decode stage
  input  wire logic                   DEC_VALID,
  input  wire oag_pkg::oag_mode_type  DEC_MODE,
  input  wire oag_pkg::oag_op_type    DEC_OP,
  input  wire logic                   DEC_WORD,
  input  wire logic                   DEC_SHORT_REG,
  input  wire logic                   DEC_SHORT_OFS,
  input  wire logic [7:0]             DEC_FIELD,
  input  wire logic [15:0]            DEC_IMM,
  input  wire logic [15:0]            DEC_PC_NEXT,
  // register operands from the register file
  input  wire logic [7:0]             RF_BYTE,
  input  wire logic [15:0]            RF_PAIR,
  input  wire logic                   RF_SET1,
  // window pointers
  input  wire logic                   PTR_WE,
  input  wire logic                   PTR_SEL,
  input  wire logic [7:0]             PTR_WDATA,
  output logic [7:0]                  FIRST_PTR,
  output logic [7:0]                  SECOND_PTR,
  // effective address
  output logic [15:0]                 EA_ADDR,
  output oag_pkg::oag_space_type      EA_SPACE,
  output logic                        EA_WORD,
  output logic                        EA_VALID,
  output logic                        EA_ILLEGAL,
  output logic [15:0]                 EA_OPERAND,
  output logic                        EA_OPERAND_VALID
);
  logic [7:0] first_ptr_ff;
  logic [7:0] second_ptr_ff;
  logic [7:0] nxt_first_ptr;
  logic [7:0] nxt_second_ptr;

  oag_wreg_if wr ();

  oag_wreg_resolve u_resolve (
    .wr (wr)
  );

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the decode below serves three-bit modes and two-bit spaces only
  if ($bits(oag_pkg::oag_mode_type) != 3) begin : g_mode_width
    $error("mode code width unsupported");
  end
  if ($bits(oag_pkg::oag_space_type) != 2) begin : g_space_width
    $error("space code width unsupported");
  end
  if (oag_pkg::WORK_SEL_BIT != 3) begin : g_sel_bit
    $error("window select bit unsupported");
  end

  // ----------------------------------------------------------------
  // window pointers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_first_ptr  = first_ptr_ff;
    nxt_second_ptr = second_ptr_ff;
    if (PTR_WE && !PTR_SEL) begin
      nxt_first_ptr = PTR_WDATA;
    end
    if (PTR_WE && PTR_SEL) begin
      nxt_second_ptr = PTR_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      first_ptr_ff  <= oag_pkg::PTR_RST_0;
      second_ptr_ff <= oag_pkg::PTR_RST_1;
    end else begin
      first_ptr_ff  <= nxt_first_ptr;
      second_ptr_ff <= nxt_second_ptr;
    end
  end

  assign FIRST_PTR     = first_ptr_ff;
  assign SECOND_PTR    = second_ptr_ff;
  assign wr.first_ptr  = first_ptr_ff;
  assign wr.second_ptr = second_ptr_ff;
  assign wr.raw_addr   = DEC_FIELD;
  assign wr.is_short   = DEC_SHORT_REG;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  // set 1 control area is 0xc0..0xff while the set 1 select is high
  function automatic logic in_ctrl(input logic [7:0] a, input logic s1);
    in_ctrl = s1 && (a[7:6] == oag_pkg::CTRL_AREA_TOP);
  endfunction

  function automatic logic is_branch(input oag_pkg::oag_op_type op);
    is_branch = (op == oag_pkg::OAG_OP_BTB_FALSE) ||
                (op == oag_pkg::OAG_OP_BTB_TRUE)  ||
                (op == oag_pkg::OAG_OP_DEC_BR)    ||
                (op == oag_pkg::OAG_OP_CMP_EQ)    ||
                (op == oag_pkg::OAG_OP_CMP_NE)    ||
                (op == oag_pkg::OAG_OP_SHORT_JMP);
  endfunction

  function automatic oag_pkg::oag_space_type mem_space(
    input oag_pkg::oag_op_type op);
    mem_space = (op == oag_pkg::OAG_OP_EXT_LOAD) ? oag_pkg::OAG_SPACE_EXT
                                                 : oag_pkg::OAG_SPACE_PROG;
  endfunction

  // ----------------------------------------------------------------
  // effective address, purely combinational
  // ----------------------------------------------------------------
  logic       mem_op;
  logic [7:0] idx_reg;

  always_comb begin
    mem_op  = (DEC_OP == oag_pkg::OAG_OP_PROG_LOAD) ||
              (DEC_OP == oag_pkg::OAG_OP_EXT_LOAD);
    idx_reg = 8'h00;
    EA_ADDR          = oag_pkg::NULL_ADDR;
    EA_SPACE         = oag_pkg::OAG_SPACE_REG;
    EA_WORD          = DEC_WORD;
    EA_ILLEGAL       = 1'b0;
    EA_OPERAND       = oag_pkg::NULL_ADDR;
    EA_OPERAND_VALID = 1'b0;
    unique case (DEC_MODE)
      oag_pkg::OAG_MODE_REG: begin
        // pairs always start on the even register
        EA_ADDR = {8'h00, DEC_WORD ? (wr.reg_addr & oag_pkg::PAIR_EVEN_MASK)
                                   : wr.reg_addr};
      end
      oag_pkg::OAG_MODE_PTR_REG: begin
        if (mem_op) begin
          EA_ADDR  = RF_PAIR;
          EA_SPACE = mem_space(DEC_OP);
        end else begin
          EA_ADDR    = {8'h00, RF_BYTE};
          EA_ILLEGAL = in_ctrl(RF_BYTE, RF_SET1);
        end
      end
      oag_pkg::OAG_MODE_INDEXED: begin
        if (mem_op) begin
          EA_SPACE = mem_space(DEC_OP);
          if (DEC_SHORT_OFS) begin
            // short form only serves external memory
            EA_ADDR    = RF_PAIR + sext8(DEC_IMM[7:0]);
            EA_ILLEGAL = (DEC_OP != oag_pkg::OAG_OP_EXT_LOAD);
          end else begin
            EA_ADDR = RF_PAIR + DEC_IMM;
          end
        end else begin
          idx_reg    = DEC_FIELD + RF_BYTE;
          EA_ADDR    = {8'h00, idx_reg};
          EA_ILLEGAL = (DEC_OP != oag_pkg::OAG_OP_REG_LOAD) ||
                       in_ctrl(idx_reg, RF_SET1);
        end
      end
      oag_pkg::OAG_MODE_DIRECT: begin
        EA_ADDR = DEC_IMM;
        if (mem_op) begin
          EA_SPACE = mem_space(DEC_OP);
        end else begin
          EA_SPACE   = oag_pkg::OAG_SPACE_PC;
          EA_ILLEGAL = (DEC_OP != oag_pkg::OAG_OP_JUMP) &&
                       (DEC_OP != oag_pkg::OAG_OP_CALL);
        end
      end
      oag_pkg::OAG_MODE_VECTOR: begin
        EA_ADDR    = {oag_pkg::VECTOR_HI_BYTE, DEC_FIELD};
        EA_SPACE   = oag_pkg::OAG_SPACE_PROG;
        EA_WORD    = 1'b1;
        EA_ILLEGAL = (DEC_OP != oag_pkg::OAG_OP_CALL);
      end
      oag_pkg::OAG_MODE_REL: begin
        EA_ADDR    = DEC_PC_NEXT + sext8(DEC_FIELD);
        EA_SPACE   = oag_pkg::OAG_SPACE_PC;
        EA_ILLEGAL = !is_branch(DEC_OP);
      end
      oag_pkg::OAG_MODE_LITERAL: begin
        EA_OPERAND = DEC_WORD ? DEC_IMM : {8'h00, DEC_IMM[7:0]};
        EA_OPERAND_VALID = 1'b1;
      end
      default: begin
        EA_ILLEGAL = 1'b1;
      end
    endcase
    if (!DEC_VALID) begin
      EA_ILLEGAL       = 1'b0;
      EA_OPERAND_VALID = 1'b0;
    end
  end

  assign EA_VALID = DEC_VALID && !EA_ILLEGAL;
endmodule

// ---- bench/oag_monitor.sv ----
`timescale 1ns/1ns
module oag_monitor (
  // clock and reset
  input wire logic                  SYS_CLK,
  input wire logic                  NRST,
  // decode side
  input wire logic                  DEC_VALID,
  input wire oag_pkg::oag_mode_type DEC_MODE,
  input wire oag_pkg::oag_op_type   DEC_OP,
  input wire logic                  DEC_WORD,
  input wire logic [7:0]            DEC_FIELD,
  input wire logic [15:0]           DEC_IMM,
  input wire logic [15:0]           DEC_PC_NEXT,
  input wire logic [7:0]            RF_BYTE,
  input wire logic                  RF_SET1,
  // window pointers
  input wire logic                  PTR_WE,
  input wire logic                  PTR_SEL,
  input wire logic [7:0]            PTR_WDATA,
  input wire logic [7:0]            FIRST_PTR,
  input wire logic [7:0]            SECOND_PTR,
  // effective address
  input wire logic [15:0]           EA_ADDR,
  input wire logic                  EA_VALID,
  input wire logic                  EA_ILLEGAL,
  input wire logic [15:0]           EA_OPERAND,
  input wire logic                  EA_OPERAND_VALID
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  wire rel = DEC_VALID && DEC_MODE == oag_pkg::OAG_MODE_REL;
  wire vec = DEC_VALID && DEC_MODE == oag_pkg::OAG_MODE_VECTOR;
  a_rel_target: assert property (rel && !EA_ILLEGAL |->
    EA_ADDR == DEC_PC_NEXT + {{8{DEC_FIELD[7]}}, DEC_FIELD})
    else $error("relative target wrong");
  a_rel_generic: assert property (
    rel && DEC_OP == oag_pkg::OAG_OP_GENERIC |-> EA_ILLEGAL)
    else $error("relative mode taken by generic op");
  a_vector_page: assert property (vec && !EA_ILLEGAL |->
    EA_ADDR[15:8] == 8'h00 && EA_ADDR[7:1] == DEC_FIELD[7:1])
    else $error("vector address outside low page");
  a_vector_call: assert property (
    vec && DEC_OP != oag_pkg::OAG_OP_CALL |-> EA_ILLEGAL)
    else $error("vector mode taken by non-call");
  a_direct_addr: assert property (DEC_VALID && EA_VALID &&
    DEC_MODE == oag_pkg::OAG_MODE_DIRECT |-> EA_ADDR == DEC_IMM)
    else $error("direct address wrong");
  // memory loads point through a pair, so only register targets are refused
  a_ptr_ctrl: assert property (
    DEC_VALID && !DEC_WORD && RF_SET1 && RF_BYTE[7:6] == 2'b11 &&
    DEC_MODE == oag_pkg::OAG_MODE_PTR_REG &&
    DEC_OP != oag_pkg::OAG_OP_PROG_LOAD &&
    DEC_OP != oag_pkg::OAG_OP_EXT_LOAD
    |-> EA_ILLEGAL && !EA_VALID) else $error("control area reached");
  a_idle_quiet: assert property (
    !DEC_VALID |-> !EA_VALID && !EA_ILLEGAL)
    else $error("address flags without decode");
  a_literal_word: assert property (DEC_VALID && DEC_WORD &&
    DEC_MODE == oag_pkg::OAG_MODE_LITERAL |-> EA_OPERAND_VALID &&
    EA_OPERAND == DEC_IMM) else $error("literal word wrong");
  a_ptr_load: assert property (PTR_WE |=>
    ($past(PTR_SEL) ? SECOND_PTR : FIRST_PTR) == $past(PTR_WDATA))
    else $error("pointer write lost");
  a_ptr_hold: assert property (
    !PTR_WE |=> $stable({FIRST_PTR, SECOND_PTR}))
    else $error("pointer changed without write");
  c_rel: cover property (rel && EA_VALID);
  c_vec: cover property (vec && EA_VALID);
  c_ctrl: cover property (DEC_VALID && RF_SET1 && EA_ILLEGAL);
endmodule

// ---- bench/oag_rf_model.sv ----
`timescale 1ns/1ns
// register file stand-in: every location holds a byte unlike its neighbours,
// and each even/odd pair shares one pair value, so a wrong pick shows up
module oag_rf_model (
  // lookup of the named register
  input  wire logic [7:0]  addr,
  output logic      [7:0]  byte_q,
  output logic      [15:0] pair_q
);
  assign byte_q = addr ^ 8'h5a;
  assign pair_q = {addr & 8'hfe, addr | 8'h01};
endmodule

// ---- bench/oag_top_tb.sv ----
`timescale 1ns/1ns
module oag_top_tb;
  logic clk = 0, nrst = 0, dv = 0, wd = 0, sr = 0, so = 0, set1 = 0;
  logic we = 0, sel = 0;
  logic [7:0] fld = 0, wdat = 0, rsel = 0, rb, fp, sp;
  logic [15:0] imm = 0, pc = 0, rp, ea, opd;
  oag_pkg::oag_mode_type md = oag_pkg::OAG_MODE_REG;
  oag_pkg::oag_op_type op = oag_pkg::OAG_OP_GENERIC;
  oag_pkg::oag_space_type spc;
  logic ew, ev, ei, ov;
  int failures = 0, checked = 0;
  initial forever #50 clk = ~clk;
  oag_rf_model u_rf (.addr(rsel), .byte_q(rb), .pair_q(rp));
  oag_top DUT (.SYS_CLK(clk), .NRST(nrst), .DEC_VALID(dv), .DEC_MODE(md),
    .DEC_OP(op), .DEC_WORD(wd), .DEC_SHORT_REG(sr), .DEC_SHORT_OFS(so),
    .DEC_FIELD(fld), .DEC_IMM(imm), .DEC_PC_NEXT(pc), .RF_BYTE(rb),
    .RF_PAIR(rp), .RF_SET1(set1), .PTR_WE(we), .PTR_SEL(sel),
    .PTR_WDATA(wdat), .FIRST_PTR(fp), .SECOND_PTR(sp), .EA_ADDR(ea),
    .EA_SPACE(spc), .EA_WORD(ew), .EA_VALID(ev), .EA_ILLEGAL(ei),
    .EA_OPERAND(opd), .EA_OPERAND_VALID(ov));
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // apply one decode after the edge, then let it settle before judging
  task ap(input logic [2:0] m, input logic [3:0] o, input logic [7:0] f,
          input logic [15:0] i, input logic w, input logic s);
    @(posedge clk);
    #1;
    dv = 1; md = oag_pkg::oag_mode_type'(m); op = oag_pkg::oag_op_type'(o);
    fld = f; imm = i; wd = w; sr = s;
    #20;
  endtask
  task ptr_wr(input logic s, input logic [7:0] d);
    @(posedge clk);
    #1;
    we = 1; sel = s; wdat = d;
    @(posedge clk);
    #1;
    we = 0;
  endtask
  task t_work;
    chk("first ptr", {8'h00, fp}, 16'h00c0);
    chk("second ptr", {8'h00, sp}, 16'h00c8);
    ptr_wr(0, 8'h70);
    ptr_wr(1, 8'ha8);
    ap(3'h0, 4'h0, 8'h06, 16'h0000, 0, 1);
    chk("short wreg", ea, 16'h0076);
    ap(3'h0, 4'h0, 8'h0e, 16'h0000, 0, 1);
    chk("short wreg hi", ea, 16'h00ae);
    ap(3'h0, 4'h0, 8'hcb, 16'h0000, 0, 0);
    chk("long wreg", ea, 16'h00ab);
    ap(3'h0, 4'h0, 8'h40, 16'h0000, 0, 0);
    chk("plain reg", ea, 16'h0040);
  endtask
  task t_ptr_idx;
    rsel = 8'h10; set1 = 0;
    ap(3'h1, 4'h0, 8'h10, 16'h0000, 0, 0);
    chk("ptr byte", ea, 16'h004a);
    rsel = 8'h9a; set1 = 1;
    ap(3'h1, 4'h0, 8'h9a, 16'h0000, 0, 0);
    chk("ptr ctrl", {15'h0000, ei}, 16'h0001);
    rsel = 8'h20; set1 = 0;
    ap(3'h1, 4'h2, 8'h20, 16'h0000, 1, 0);
    chk("ptr pair", ea, 16'h2021);
    rsel = 8'h1a;
    ap(3'h2, 4'h1, 8'hf0, 16'h0000, 0, 0);
    chk("idx reg wrap", ea, 16'h0030);
    set1 = 1;
    ap(3'h2, 4'h1, 8'h80, 16'h0000, 0, 0);
    chk("idx ctrl", {15'h0000, ei}, 16'h0001);
    ap(3'h2, 4'h0, 8'h10, 16'h0000, 0, 0);
    chk("idx generic", {15'h0000, ei}, 16'h0001);
    set1 = 0; rsel = 8'h30; so = 1;
    ap(3'h2, 4'h3, 8'h30, 16'h0080, 0, 0);
    chk("idx short", ea, 16'h2fb1);
    ap(3'h2, 4'h2, 8'h30, 16'h0080, 0, 0);
    chk("short on prog", {15'h0000, ei}, 16'h0001);
    so = 0;
    ap(3'h2, 4'h2, 8'h30, 16'h1234, 0, 0);
    chk("idx long", ea, 16'h4265);
  endtask
  task t_flow;
    ap(3'h3, 4'h4, 8'h00, 16'hbeef, 0, 0);
    chk("direct jump", ea, 16'hbeef);
    ap(3'h3, 4'h3, 8'h00, 16'h1357, 0, 0);
    chk("direct ext", {14'h0000, spc}, 16'h0002);
    ap(3'h4, 4'h5, 8'h40, 16'h0000, 0, 0);
    chk("vector", ea, 16'h0040);
    chk("vector pair", {15'h0000, ew}, 16'h0001);
    ap(3'h4, 4'h4, 8'h40, 16'h0000, 0, 0);
    chk("vector jump", {15'h0000, ei}, 16'h0001);
    pc = 16'h0100;
    for (int k = 6; k < 12; k++) begin
      ap(3'h5, 4'(k), 8'h80, 16'h0000, 0, 0);
      chk("rel back", ea, 16'h0080);
      chk("rel space", {14'h0000, spc}, 16'h0003);
    end
    pc = 16'hfff0;
    ap(3'h5, 4'hb, 8'h7f, 16'h0000, 0, 0);
    chk("rel fwd wrap", ea, 16'h006f);
    ap(3'h5, 4'h0, 8'h7f, 16'h0000, 0, 0);
    chk("rel generic", {15'h0000, ei}, 16'h0001);
    ap(3'h6, 4'h0, 8'h00, 16'ha5c3, 1, 0);
    chk("lit word", opd, 16'ha5c3);
    chk("lit valid", {14'h0000, ov, ev}, 16'h0003);
    ap(3'h6, 4'h0, 8'h00, 16'h1234, 0, 0);
    chk("lit byte", opd, 16'h0034);
    ap(3'h7, 4'h0, 8'h00, 16'h0000, 0, 0);
    chk("mode seven", {15'h0000, ei}, 16'h0001);
    dv = 0;
    #20;
    chk("idle", {14'h0000, ev, ei}, 16'h0000);
  endtask
  task wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1;
    t_work;
    t_ptr_idx;
    t_flow;
    wrap_up;
  end
endmodule
bind oag_top oag_monitor u_mon (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .DEC_VALID(DEC_VALID), .DEC_MODE(DEC_MODE), .DEC_OP(DEC_OP),
  .DEC_WORD(DEC_WORD), .DEC_FIELD(DEC_FIELD), .DEC_IMM(DEC_IMM),
  .DEC_PC_NEXT(DEC_PC_NEXT), .RF_BYTE(RF_BYTE), .RF_SET1(RF_SET1),
  .PTR_WE(PTR_WE), .PTR_SEL(PTR_SEL), .PTR_WDATA(PTR_WDATA),
  .FIRST_PTR(FIRST_PTR), .SECOND_PTR(SECOND_PTR), .EA_ADDR(EA_ADDR),
  .EA_VALID(EA_VALID), .EA_ILLEGAL(EA_ILLEGAL), .EA_OPERAND(EA_OPERAND),
  .EA_OPERAND_VALID(EA_OPERAND_VALID));
